// file: hw/vif_pkg.sv
// vif_pkg: constants and types shared by the instruction-status unit.
// assumes a single 100 MHz core clock and an AHB-Lite register port.
package vif_pkg;

  // register byte offsets, one aligned word each
  localparam logic [7:0] OFS_CMD      = 8'h00; // instruction issue
  localparam logic [7:0] OFS_COND     = 8'h04; // check inputs from core
  localparam logic [7:0] OFS_RESULT   = 8'h08; // flags and error field
  localparam logic [7:0] OFS_STATE    = 8'h0C; // structure and mode state
  localparam logic [7:0] OFS_IRQSTAT  = 8'h10; // sticky events, w1c
  localparam logic [7:0] OFS_IRQMASK  = 8'h14; // interrupt mask
  localparam logic [7:0] OFS_EXITRSN  = 8'h18; // exit-reason field

  // instruction codes written to the command register
  localparam logic [3:0] OP_LAUNCH    = 4'h1;
  localparam logic [3:0] OP_RESUME    = 4'h2;
  localparam logic [3:0] OP_FLUSH     = 4'h3;
  localparam logic [3:0] OP_LOADPTR   = 4'h4;
  localparam logic [3:0] OP_STOREPTR  = 4'h5;
  localparam logic [3:0] OP_LEAVE     = 4'h6;
  localparam logic [3:0] OP_ENTER     = 4'h7;
  localparam logic [3:0] OP_FIELDRD   = 4'h8;
  localparam logic [3:0] OP_FIELDWR   = 4'h9;
  localparam logic [3:0] OP_GUESTEXIT = 4'hA;

  // instruction error numbers
  localparam logic [7:0] ERR_NONE     = 8'h00;
  localparam logic [7:0] ERR_NOTCLEAR = 8'h04;
  localparam logic [7:0] ERR_NOTLNCH  = 8'h05;
  localparam logic [7:0] ERR_REENTER  = 8'h06;
  localparam logic [7:0] ERR_CTRL     = 8'h07;
  localparam logic [7:0] ERR_HOST     = 8'h08;

  // bit positions
  localparam int EXIT_FAILBIT = 31;
  localparam int IRQ_FAILCF   = 0;
  localparam int IRQ_FAILZF   = 1;
  localparam int IRQ_EXIT     = 2;
  localparam int IRQ_ENTRYERR = 3;
  localparam int IRQ_W        = 4;

  // reset values
  localparam logic [IRQ_W-1:0] IRQMASK_RST = 4'h0;

  // inputs the core presents for the entry checks
  typedef struct packed {
    logic ctrlBad;       // control fields invalid
    logic hostBad;       // host-state area invalid
    logic guestLoadBad;  // guest-state or msr load failed
    logic unrestricted;  // unrestricted-guest control set and supported
    logic peBit;         // guest protection_enable_bit
    logic pgBit;         // guest paging_enable_bit
    logic longGuest;     // long-mode-guest entry control
    logic loadFeat;      // load-extended-features entry control
    logic lmaBit;        // guest long_mode_active_bit at exit
  } vif_cond_t;

  // outcome of one instruction
  typedef struct packed {
    logic       carryFlag;
    logic       zeroFlag;
    logic [7:0] errNum;
    logic       writeErr;
  } vif_result_t;

  // check order: pointer, launch state, controls, host state
  function automatic vif_result_t vif_judge(
      input logic [3:0] op, input logic ptrValid, input logic launched,
      input logic reentered, input vif_cond_t c);
    vif_result_t r;
    r = '{carryFlag: 1'b0, zeroFlag: 1'b0, errNum: ERR_NONE, writeErr: 1'b0};
    if (!ptrValid && op != OP_LOADPTR && op != OP_ENTER && op != OP_LEAVE) begin
      r.carryFlag = 1'b1;
    end else if (op == OP_LAUNCH && launched) begin
      r.zeroFlag = 1'b1;
      r.errNum   = ERR_NOTCLEAR;
    end else if (op == OP_RESUME && !launched) begin
      r.zeroFlag = 1'b1;
      r.errNum   = ERR_NOTLNCH;
    end else if (op == OP_RESUME && reentered) begin
      r.zeroFlag = 1'b1;
      r.errNum   = ERR_REENTER;
    end else if ((op == OP_LAUNCH || op == OP_RESUME) && c.ctrlBad) begin
      r.zeroFlag = 1'b1;
      r.errNum   = ERR_CTRL;
    end else if ((op == OP_LAUNCH || op == OP_RESUME) && c.hostBad) begin
      r.zeroFlag = 1'b1;
      r.errNum   = ERR_HOST;
    end
    r.writeErr = r.zeroFlag;
    return r;
  endfunction

endpackage

// file: hw/vif_ahb_slave.sv
// vif_ahb_slave: AHB-Lite word slave front end, zero wait states.
// assumes single whole-word transfers; always answers OKAY.
`timescale 1ns/1ps
module vif_ahb_slave (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // ahb-lite slave side
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  // register side
  output logic             wrEn,
  output logic             rdEn,
  output logic [7:0]       regAddr
);

  logic       phaseWr;   // data phase of a write pending
  logic [7:0] phaseAddr; // latched address of the data phase

  // address phase is taken only for nonseq/seq with hready high
  wire addrTaken = hsel & hready & htrans[1];

  //////////////////////////////////////////////////////////////////////
  // latch the address phase
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phaseWr   <= 1'b0;
      phaseAddr <= 8'h00;
    end else begin
      phaseWr   <= addrTaken & hwrite;
      if (addrTaken) begin
        phaseAddr <= haddr[7:0];
      end
    end
  end

  // writes land in the data phase, reads decode in the address phase
  assign wrEn      = phaseWr;
  assign rdEn      = addrTaken & ~hwrite;
  assign regAddr   = phaseWr ? phaseAddr : haddr[7:0];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

endmodule // vif_ahb_slave

// file: hw/vif_status_unit.sv
// vif_status_unit: failure reporting for virt_extensions instructions.
// assumes core supplies check inputs via register; AHB-Lite software port.
//
// Function
// - guest-mode instruction causes exit, not execution
// - invalid pointer failure sets carry_flag
// - valid pointer failure sets zero_flag, error
// - launch on non-clear structure gives error 4
// - resume on unlaunched structure gives error 5
// - resume after leave and reenter: error 6
// - then controls (7) or host state (8)
// - entry needs protection and paging bits set
// - unrestricted guest allows real and unpaged modes
// - paging off, both controls zero: keep host bit
// - exit copies long-mode-active into entry control; here only when the unrestricted input is set
// - fields reached only through field instructions
// - flush writes cached structure state back
// - entry load failure: host state, exit bit 31
`timescale 1ns/1ps
module vif_status_unit (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic [2:0]  hsize,
  input  wire logic        hwrite,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // core side
  input  wire logic        hostLongModeEnable,
  output logic             longModeEnable,
  output logic             flushWriteback,
  output logic             irq
);

  //////////////////////////////////////////////////////////////////////
  // state
  logic                     ptrValid;     // working pointer loaded
  logic                     launched;     // structure launched, not clear
  logic                     reentered;    // leave+enter since launch
  logic                     virtOn;       // in virt_extensions operation
  logic                     guestMode;    // non-root operation
  logic                     carryFlag;    // instruction result flag
  logic                     zeroFlag;     // instruction result flag
  logic [7:0]               instrErr;     // instruction-error field
  logic [31:0]              exitReason;   // exit-reason field
  logic                     longGuestCtl; // long-mode-guest entry control
  vif_pkg::vif_cond_t       cond;         // check inputs
  logic [vif_pkg::IRQ_W-1:0] irqStat;     // sticky events
  logic [vif_pkg::IRQ_W-1:0] irqMask;     // enables
  logic                     irqMaskedAny;

  // bus decode
  logic       wrEn;
  logic       rdEn;
  logic [7:0] regAddr;

  vif_ahb_slave u_bus (
    .clk       (clk),
    .reset_n   (reset_n),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .wrEn      (wrEn),
    .rdEn      (rdEn),
    .regAddr   (regAddr)
  );

  //////////////////////////////////////////////////////////////////////
  // decode of writes
  wire        cmdWr    = wrEn && regAddr == vif_pkg::OFS_CMD;
  wire        condWr   = wrEn && regAddr == vif_pkg::OFS_COND;
  wire        statWr   = wrEn && regAddr == vif_pkg::OFS_IRQSTAT;
  wire        maskWr   = wrEn && regAddr == vif_pkg::OFS_IRQMASK;
  wire [3:0]  op       = hwdata[3:0];
  wire        isEntry  = op == vif_pkg::OP_LAUNCH || op == vif_pkg::OP_RESUME;
  wire        isExitOp = op == vif_pkg::OP_GUESTEXIT;

  // any instruction in guest mode traps instead of running
  wire trapExit  = cmdWr && guestMode && !isExitOp;
  wire execCmd   = cmdWr && !guestMode && virtOn;
  wire enterCmd  = cmdWr && !guestMode && !virtOn && op == vif_pkg::OP_ENTER;
  wire guestExit = cmdWr && guestMode && isExitOp;

  // mode legality: restricted parts need protection and paging
  wire modeOk    = cond.unrestricted || (cond.peBit && cond.pgBit);

  // field read and write are judged like any instruction; no direct path
  vif_pkg::vif_result_t judged;
  assign judged  = vif_pkg::vif_judge(op, ptrValid, launched, reentered, cond);
  wire modeFail  = execCmd && isEntry && !judged.carryFlag && !judged.zeroFlag && !modeOk;
  wire checkFail = judged.carryFlag || judged.zeroFlag || modeFail;
  wire entryGo   = execCmd && isEntry && !checkFail;
  // load failure after general checks: host state, no guest save
  wire loadFail  = entryGo && cond.guestLoadBad;
  wire entryOk   = entryGo && !cond.guestLoadBad;

  // long mode enable at host value outside guest mode or with paging and both controls off
  wire keepLme   = !cond.pgBit && !cond.longGuest && !cond.loadFeat;
  assign longModeEnable = (keepLme || !guestMode) ? hostLongModeEnable
                                                  : cond.longGuest;

  // flush pulse that writes cached structure state back
  assign flushWriteback = execCmd && op == vif_pkg::OP_FLUSH && ptrValid;

  //////////////////////////////////////////////////////////////////////
  // structure launch state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ptrValid  <= 1'b0;
      launched  <= 1'b0;
      reentered <= 1'b0;
      virtOn    <= 1'b0;
      guestMode <= 1'b0;
    end else begin
      if (enterCmd) begin
        virtOn <= 1'b1;
        // leave and reenter since launch poisons resume
        if (launched) begin
          reentered <= 1'b1;
        end
      end
      if (execCmd) begin
        unique case (op)
          vif_pkg::OP_LEAVE: begin
            virtOn   <= 1'b0;
            ptrValid <= 1'b0;
          end
          vif_pkg::OP_LOADPTR: begin
            ptrValid <= 1'b1;
          end
          vif_pkg::OP_FLUSH: begin
            // flush returns the structure to the clear state
            if (ptrValid) begin
              launched  <= 1'b0;
              reentered <= 1'b0;
            end
          end
          default: begin
          end
        endcase
      end
      if (entryOk) begin
        launched  <= 1'b1;
        guestMode <= 1'b1;
      end
      if (trapExit || guestExit) begin
        guestMode <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // flags, error field and exit reason
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      carryFlag    <= 1'b0;
      zeroFlag     <= 1'b0;
      instrErr     <= vif_pkg::ERR_NONE;
      exitReason   <= 32'h0000_0000;
      longGuestCtl <= 1'b0;
    end else begin
      if (execCmd) begin
        carryFlag <= judged.carryFlag;
        zeroFlag  <= judged.zeroFlag || modeFail;
        // ordering of 4..8 lives in the judge function
        if (judged.writeErr) begin
          instrErr <= judged.errNum;
        end else if (modeFail) begin
          instrErr <= vif_pkg::ERR_CTRL;
        end
      end
      if (loadFail) begin
        exitReason[vif_pkg::EXIT_FAILBIT] <= 1'b1;
      end else if (trapExit || guestExit) begin
        exitReason <= {28'h000_0000, op};
      end
      // exits with unrestricted set record guest long-mode activity into the entry control
      if ((trapExit || guestExit) && cond.unrestricted) begin
        longGuestCtl <= cond.lmaBit;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // check inputs from software or core model
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cond <= '0;
    end else if (condWr) begin
      cond <= vif_pkg::vif_cond_t'(hwdata[8:0]);
    end else if ((trapExit || guestExit) && cond.unrestricted) begin
      cond.longGuest <= cond.lmaBit;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // interrupt status: set wins over write-one-to-clear
  wire [vif_pkg::IRQ_W-1:0] irqEvt = {loadFail,
                                      trapExit || guestExit,
                                      execCmd && (judged.zeroFlag || modeFail),
                                      execCmd && judged.carryFlag};
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irqStat <= '0;
      irqMask <= vif_pkg::IRQMASK_RST;
    end else begin
      irqStat <= (irqStat & ~(statWr ? hwdata[vif_pkg::IRQ_W-1:0] : '0)) | irqEvt;
      if (maskWr) begin
        irqMask <= hwdata[vif_pkg::IRQ_W-1:0];
      end
    end
  end
  assign irqMaskedAny = |(irqStat & irqMask);
  assign irq          = irqMaskedAny;

  //////////////////////////////////////////////////////////////////////
  // read mux, registered for the data phase
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0000_0000;
    unique case (regAddr)
      vif_pkg::OFS_COND:    rdMux = {23'h00_0000, cond};
      vif_pkg::OFS_RESULT:  rdMux = {14'h0000, instrErr, 8'h00, carryFlag, zeroFlag};
      vif_pkg::OFS_STATE:   rdMux = {26'h000_0000, longGuestCtl, guestMode,
                                     virtOn, reentered, launched, ptrValid};
      vif_pkg::OFS_IRQSTAT: rdMux = {28'h000_0000, irqStat};
      vif_pkg::OFS_IRQMASK: rdMux = {28'h000_0000, irqMask};
      vif_pkg::OFS_EXITRSN: rdMux = exitReason;
      default:              rdMux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hrdata <= 32'h0000_0000;
    end else if (rdEn) begin
      hrdata <= rdMux;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // checks

  // a guest-mode instruction leaves guest mode and flags an exit
  AST_GUEST_TRAP: assert property (@(posedge clk) disable iff (!reset_n)
    trapExit |=> !guestMode && irqStat[vif_pkg::IRQ_EXIT])
    else $error("guest-mode instruction did not exit");

  // a trapped instruction must leave the result untouched
  AST_GUEST_NOEXEC: assert property (@(posedge clk) disable iff (!reset_n)
    (cmdWr && guestMode) |=> $stable(carryFlag) && $stable(zeroFlag) && $stable(instrErr))
    else $error("guest-mode instruction changed the result");

  // no working pointer: carry flag only
  AST_CF_BADPTR: assert property (@(posedge clk) disable iff (!reset_n)
    (execCmd && !ptrValid && op == vif_pkg::OP_LAUNCH) |=> carryFlag && !zeroFlag)
    else $error("carry flag not set for invalid pointer");

  // carry failures have no structure to write an error into
  AST_CF_NOERR: assert property (@(posedge clk) disable iff (!reset_n)
    (execCmd && judged.carryFlag) |=> carryFlag && $stable(instrErr))
    else $error("carry failure wrote the error field");

  // zero flag failures record their number
  AST_ZF_ERR: assert property (@(posedge clk) disable iff (!reset_n)
    (execCmd && judged.zeroFlag) |=> zeroFlag && instrErr == $past(judged.errNum))
    else $error("zero flag or error number wrong");

  // launch on a structure that is not clear
  AST_LAUNCH4: assert property (@(posedge clk) disable iff (!reset_n)
    (execCmd && ptrValid && launched && op == vif_pkg::OP_LAUNCH)
    |=> instrErr == vif_pkg::ERR_NOTCLEAR)
    else $error("launch on non-clear not error 4");

  // resume on a structure never launched
  AST_RESUME5: assert property (@(posedge clk) disable iff (!reset_n)
    (execCmd && ptrValid && !launched && op == vif_pkg::OP_RESUME)
    |=> instrErr == vif_pkg::ERR_NOTLNCH)
    else $error("resume on unlaunched not error 5");

  // resume after leaving and reentering since the launch
  AST_RESUME6: assert property (@(posedge clk) disable iff (!reset_n)
    (execCmd && ptrValid && launched && reentered && op == vif_pkg::OP_RESUME)
    |=> instrErr == vif_pkg::ERR_REENTER && !guestMode)
    else $error("resume after reenter not error 6");

  // bad controls on a clean launch give error 7
  AST_CTRL7: assert property (@(posedge clk) disable iff (!reset_n)
    (execCmd && ptrValid && !launched && op == vif_pkg::OP_LAUNCH && cond.ctrlBad)
    |=> zeroFlag && instrErr == vif_pkg::ERR_CTRL)
    else $error("launch with bad controls not error 7");

  // an entry that goes ahead has passed control and host checks
  AST_CHECKED: assert property (@(posedge clk) disable iff (!reset_n)
    entryGo |-> !cond.ctrlBad && !cond.hostBad)
    else $error("entry went ahead with bad controls or host state");

  // a successful entry clears both flags and keeps the error
  AST_SUCCESS: assert property (@(posedge clk) disable iff (!reset_n)
    entryOk |=> !carryFlag && !zeroFlag && $stable(instrErr) && guestMode)
    else $error("success did not clear flags");

  // guest load failure: host state kept, failure bit in exit reason
  AST_LOADFAIL: assert property (@(posedge clk) disable iff (!reset_n)
    loadFail |=> exitReason[vif_pkg::EXIT_FAILBIT] && !guestMode)
    else $error("load failure not reported in exit reason");

  // restricted parts enter only with protection and paging on
  AST_MODE: assert property (@(posedge clk) disable iff (!reset_n)
    (entryOk && !cond.unrestricted) |-> cond.peBit && cond.pgBit)
    else $error("entry into unpaged mode on restricted part");

  // unrestricted guests may enter real or unpaged modes
  AST_UNRESTRICTED: assert property (@(posedge clk) disable iff (!reset_n)
    (execCmd && isEntry && !judged.carryFlag && !judged.zeroFlag
     && cond.unrestricted && !cond.guestLoadBad) |=> guestMode)
    else $error("unrestricted guest entry refused");

  // paging off with both controls clear keeps the host value
  AST_LME: assert property (@(posedge clk) disable iff (!reset_n)
    keepLme |-> longModeEnable == hostLongModeEnable)
    else $error("long mode enable not kept at host value");

  // exits with unrestricted set copy long-mode activity into the entry control
  AST_EXIT_COPY: assert property (@(posedge clk) disable iff (!reset_n)
    ((trapExit || guestExit) && cond.unrestricted) |=> longGuestCtl == $past(cond.lmaBit))
    else $error("exit did not copy long-mode activity");

  // a flush returns the structure to the clear state
  AST_FLUSH_CLEAR: assert property (@(posedge clk) disable iff (!reset_n)
    flushWriteback |=> !launched && !reentered)
    else $error("flush did not clear the launch state");

endmodule // vif_status_unit

// file: sim/tb_top.sv
// tb_top: self-checking bench for the instruction-status unit.
// assumes the zero-wait ahb-lite slave and register map of the unit.
`timescale 1ns/1ps
module tb_top;
  ////////////////////////////////////////////////////////////////////////////
  // one instruction step: condition word, opcode, expected result and state
  typedef struct packed {
    logic [3:0]  op;
    logic [8:0]  cond;
    logic [31:0] res;
    logic [7:0]  st;
  } vif_row_t;

  logic        clk;                // core clock
  logic        reset_n;            // async reset, active low
  logic        hsel;               // bus select
  logic [31:0] haddr;              // byte address
  logic [1:0]  htrans;             // transfer type
  logic [2:0]  hsize;              // always word
  logic        hwrite;             // write strobe
  logic [31:0] hwdata;             // write data
  logic [31:0] hrdata;             // read data
  logic        hreadyout;          // slave ready
  logic        hresp;              // response
  logic        hostLongModeEnable; // host long-mode value
  logic        longModeEnable;     // value seen by guest
  logic        flushWriteback;     // write-back pulse
  logic        irq;                // interrupt level
  logic [31:0] rd;                 // last read word
  int          nMismatch;          // failed comparisons
  int          nCompared;          // all comparisons
  int          nFlush;             // write-back pulses seen

  // the stepped sequence; every row depends on the state the last one left
  localparam vif_row_t ROWS [19] = '{
    '{vif_pkg::OP_ENTER,   9'h000, 32'h0000_0000, 8'h08},
    '{vif_pkg::OP_LAUNCH,  9'h000, 32'h0000_0002, 8'h08},
    '{vif_pkg::OP_FIELDWR, 9'h000, 32'h0000_0002, 8'h08},
    '{vif_pkg::OP_LOADPTR, 9'h000, 32'h0000_0000, 8'h09},
    '{vif_pkg::OP_RESUME,  9'h000, 32'h0000_1401, 8'h09},
    '{vif_pkg::OP_LAUNCH,  9'h118, 32'h0000_1C01, 8'h09},
    '{vif_pkg::OP_LAUNCH,  9'h098, 32'h0000_2001, 8'h09},
    '{vif_pkg::OP_LAUNCH,  9'h008, 32'h0000_1C01, 8'h09},
    '{vif_pkg::OP_LAUNCH,  9'h018, 32'h0000_1C00, 8'h1B},
    '{vif_pkg::OP_FLUSH,   9'h018, 32'h0000_1C00, 8'h0B},
    '{vif_pkg::OP_LAUNCH,  9'h018, 32'h0000_1001, 8'h0B},
    '{vif_pkg::OP_LEAVE,   9'h018, 32'h0000_1000, 8'h02},
    '{vif_pkg::OP_ENTER,   9'h018, 32'h0000_1000, 8'h0E},
    '{vif_pkg::OP_LOADPTR, 9'h018, 32'h0000_1000, 8'h0F},
    '{vif_pkg::OP_RESUME,  9'h018, 32'h0000_1801, 8'h0F},
    '{vif_pkg::OP_STOREPTR, 9'h018, 32'h0000_1800, 8'h0F},
    '{vif_pkg::OP_FLUSH,   9'h018, 32'h0000_1800, 8'h09},
    '{vif_pkg::OP_LOADPTR, 9'h018, 32'h0000_1800, 8'h09},
    '{vif_pkg::OP_LAUNCH,  9'h018, 32'h0000_1800, 8'h1B}};

  ////////////////////////////////////////////////////////////////////////////
  // device under test; single slave, so its ready is the bus ready
  vif_status_unit vif_status_unit_inst (
    .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hsize(hsize), .hwrite(hwrite), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .hostLongModeEnable(hostLongModeEnable), .longModeEnable(longModeEnable),
    .flushWriteback(flushWriteback), .irq(irq));

  // clock, 10 ns period
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // counts write-back pulses; a trapped flush must not add one
  always @(posedge clk) begin
    if (flushWriteback === 1'b1) nFlush++;
  end

  ////////////////////////////////////////////////////////////////////////////
  // prints counts and verdict, then ends the run
  task automatic stopTest();
    $display("compared %0d mismatched %0d", nCompared, nMismatch);
    if (nMismatch == 0 && nCompared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // word comparison, case equality so an unknown never matches
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    nCompared++;
    if (got !== exp) begin
      nMismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one single transfer; entered just after a rising edge, ends on one
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'b10;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'b00;
    hwdata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    rd = hrdata;
    if (n >= 100) begin
      nMismatch++;
      $display("CHECK FAILED bus ready expected 1 seen %b", hreadyout);
    end
  endtask

  // issue one instruction with its condition word
  task automatic issue(input logic [3:0] op, input logic [8:0] cond);
    ahb(1'b1, vif_pkg::OFS_COND, {23'h0, cond});
    // pointer operand sits on a 4 KB boundary in write-back memory
    ahb(1'b1, vif_pkg::OFS_CMD, {20'h0_0001, 8'h00, op});
  endtask

  // read a register and compare it
  task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0000_0000);
    chk(what, exp, rd);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // watchdog; the whole sequence needs well under a thousand cycles
  initial begin
    #100000;
    nMismatch++;
    $display("CHECK FAILED watchdog expected done seen hang");
    stopTest();
  end

  // main sequence
  initial begin
    nMismatch = 0;
    nCompared = 0;
    nFlush = 0;
    reset_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hsize = 3'b010;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    hostLongModeEnable = 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    // reset values and bus idle answer
    chk("irq", 32'h0, {31'h0, irq});
    chk("ready", 32'h1, {31'h0, hreadyout});
    chk("resp", 32'h0, {31'h0, hresp});
    rdChk("result", vif_pkg::OFS_RESULT, 32'h0000_0000);
    rdChk("mask", vif_pkg::OFS_IRQMASK, 32'h0000_0000);
    rdChk("unmapped", 8'h1C, 32'h0000_0000);
    $display("test reset done");
    // stepped instruction sequence
    foreach (ROWS[i]) begin
      issue(ROWS[i].op, ROWS[i].cond);
      ahb(1'b0, vif_pkg::OFS_RESULT, 32'h0);
      chk("flags", ROWS[i].res & 32'h3, rd & 32'h3);
      chk("error", ROWS[i].res & ~32'h3, rd & ~32'h3);
      ahb(1'b0, vif_pkg::OFS_STATE, 32'h0);
      chk("state", {24'h0, ROWS[i].st}, rd & 32'h0000_001F);
    end
    chk("writebacks", 32'h1, nFlush);
    $display("test sequence done");
    // exit copies active long mode into the entry control
    issue(vif_pkg::OP_GUESTEXIT, 9'h021);
    rdChk("state", vif_pkg::OFS_STATE, 32'h0000_002B);
    rdChk("cond", vif_pkg::OFS_COND, 32'h0000_0025);
    $display("test exit copy done");
    // unpaged entry with unrestricted guest, host value kept
    issue(vif_pkg::OP_RESUME, 9'h020);
    rdChk("result", vif_pkg::OFS_RESULT, 32'h0000_1800);
    ahb(1'b0, vif_pkg::OFS_STATE, 32'h0);
    chk("state", 32'h0000_001B, rd & 32'h0000_001F);
    hostLongModeEnable <= 1'b1;
    @(posedge clk);
    #1 chk("lme", 32'h1, {31'h0, longModeEnable});
    @(posedge clk);
    hostLongModeEnable <= 1'b0;
    @(posedge clk);
    #1 chk("lme", 32'h0, {31'h0, longModeEnable});
    @(posedge clk);
    // long-mode guest control set: host value no longer shows
    ahb(1'b1, vif_pkg::OFS_COND, 32'h0000_0024);
    #1 chk("lme", 32'h1, {31'h0, longModeEnable});
    @(posedge clk);
    ahb(1'b1, vif_pkg::OFS_CMD, {28'h0, vif_pkg::OP_GUESTEXIT});
    $display("test unrestricted done");
    // guest-state load failure
    issue(vif_pkg::OP_RESUME, 9'h058);
    ahb(1'b0, vif_pkg::OFS_EXITRSN, 32'h0);
    chk("exit fail", 32'h8000_0000, rd & 32'h8000_0000);
    ahb(1'b0, vif_pkg::OFS_STATE, 32'h0);
    chk("guest", 32'h0, rd & 32'h0000_0010);
    rdChk("result", vif_pkg::OFS_RESULT, 32'h0000_1800);
    $display("test load failure done");
    // every event seen so far, masked, then the exit event unmasked and cleared
    rdChk("status", vif_pkg::OFS_IRQSTAT, 32'h0000_000F);
    chk("irq", 32'h0, {31'h0, irq});
    ahb(1'b1, vif_pkg::OFS_IRQMASK, 32'h0000_0004);
    #1 chk("irq", 32'h1, {31'h0, irq});
    @(posedge clk);
    ahb(1'b1, vif_pkg::OFS_IRQSTAT, 32'h0000_0004);
    #1 chk("irq", 32'h0, {31'h0, irq});
    @(posedge clk);
    rdChk("status", vif_pkg::OFS_IRQSTAT, 32'h0000_000B);
    rdChk("mask", vif_pkg::OFS_IRQMASK, 32'h0000_0004);
    $display("test interrupt done");
    stopTest();
  end
endmodule // tb_top
